// ### bench/drv_model.sv
`default_nettype none
// behavioural inverter driver facing the controller
module drv_model (
    input wire logic clk,
    input wire gate_ctrl_pkg::cmd_s cmd,
    input wire logic high_line,
    input wire logic low_line,
    input wire logic uv1,
    input wire logic low_flt,
    output logic high_pull_n,
    output logic low_pull_n,
    output logic [2:0] high_gate,
    output logic [2:0] low_gate
);
    timeunit 1ns;
    timeprecision 1ps;
    import gate_ctrl_pkg::*;
    // ------------------------------------------------
    // gate logic
    // ------------------------------------------------
    logic [2:0] armed_r = 3'h0; // restart edge already seen
    logic [2:0] prev_r = 3'h0; // last high command
    logic [2:0] rise;
    assign rise = cmd.high_side_command & ~prev_r;
    // a shutdown disarms; only a new rising command re-arms
    always @(posedge clk) begin
        prev_r <= cmd.high_side_command;
        if (!high_line) begin
            armed_r <= 3'h0;
        end else begin
            armed_r <= armed_r | rise;
        end
    end
    // no dead time added here: commands pass straight to gates
    assign high_gate = cmd.high_side_command & (armed_r | rise) &
        {3{high_line}};
    assign low_gate = cmd.low_side_command &
        {3{low_line}};
    // low_flt stands for supply two, overcurrent or thermal, or the
    // limit flag wired onto this line; the bench holds it for as long
    // as the hold timer or the filtered, blanked sense condition would
    assign high_pull_n = !uv1;
    assign low_pull_n = !low_flt;
endmodule
`default_nettype wire

// ### bench/gate_ctrl_properties.sv
`default_nettype none
module gate_ctrl_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire gate_ctrl_pkg::cmd_s cmd,
    input wire gate_ctrl_pkg::fault_pins_s fault_pins,
    input wire logic low_side_fault_shutdown_i,
    input wire logic low_fault_seen,
    input wire logic fault_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import gate_ctrl_pkg::*;
    // ------------------------------------------------
    // port checks
    // ------------------------------------------------
    // cycles our own pull has held the high line low
    logic [13:0] pull_cnt_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pull_cnt_r <= 14'h0000;
        end else if (!fault_pins.high_side_fault_shutdown_oe_n) begin
            pull_cnt_r <= pull_cnt_r + 14'h0001;
        end else begin
            pull_cnt_r <= 14'h0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_excl;
        (cmd.high_side_command & cmd.low_side_command) == 3'h0; endproperty
    a_excl: assert property (p_excl) else $error("both on");
    property p_dead;
        $fell(cmd.high_side_command[0]) |->
            (!cmd.low_side_command[0]) [*8]; endproperty
    a_dead: assert property (p_dead) else $error("no gap");
    property p_width;
        $rose(cmd.high_side_command[0]) |->
            cmd.high_side_command[0] [*8]; endproperty
    a_width: assert property (p_width) else $error("short");
    // open drain: the data bit never drives high
    property p_od;
        !fault_pins.high_side_fault_shutdown_o &&
            !fault_pins.low_side_fault_shutdown_o; endproperty
    a_od: assert property (p_od) else $error("line driven");
    property p_sd_len;
        $rose(fault_pins.high_side_fault_shutdown_oe_n) |->
            pull_cnt_r >= 14'h04b0; endproperty
    a_sd_len: assert property (p_sd_len) else $error("pull");
    property p_off;
        $fell(low_side_fault_shutdown_i) |-> ##[1:4] cmd == 6'h00;
    endproperty
    a_off: assert property (p_off) else $error("cmd on");
    // a foreign low level must be latched within the sync delay
    property p_seen;
        (!low_side_fault_shutdown_i &&
            fault_pins.low_side_fault_shutdown_oe_n) [*5] |->
            low_fault_seen; endproperty
    a_seen: assert property (p_seen) else $error("missed");
    property p_irq;
        $rose(low_fault_seen) |-> ##[0:1] fault_irq; endproperty
    a_irq: assert property (p_irq) else $error("no irq");
endmodule
bind gate_ctrl gate_ctrl_props chk_u (
    .clk(clk),
    .arst_n(arst_n),
    .cmd(cmd),
    .fault_pins(fault_pins),
    .low_side_fault_shutdown_i(low_side_fault_shutdown_i),
    .low_fault_seen(low_fault_seen),
    .fault_irq(fault_irq)
);
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gate_ctrl_pkg::*;
    // ------------------------------------------------
    // harness
    // ------------------------------------------------
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    cmd_s req = 6'h00;
    logic sd_hi = 1'h0, sd_lo = 1'h0, clr = 1'h0;
    logic uv1 = 1'h0, low_flt = 1'h0;
    cmd_s cmd;
    fault_pins_s pins;
    logic hi_seen, lo_seen, irq, hi_pull_n, lo_pull_n;
    logic [2:0] hi_gate, lo_gate;
    wire logic hi_line, lo_line;
    int n_fail = 0;
    int n_tests = 0;
    int n;
    always #2.5 clk = ~clk;
    // pull-up lines: low if either party pulls
    assign hi_line = pins.high_side_fault_shutdown_oe_n & hi_pull_n;
    assign lo_line = pins.low_side_fault_shutdown_oe_n & lo_pull_n;
    gate_ctrl dut_u (.clk(clk), .arst_n(arst_n), .req(req),
        .shutdown_high_req(sd_hi), .shutdown_low_req(sd_lo),
        .fault_clear(clr), .high_side_fault_shutdown_i(hi_line),
        .low_side_fault_shutdown_i(lo_line), .cmd(cmd),
        .fault_pins(pins), .high_fault_seen(hi_seen),
        .low_fault_seen(lo_seen), .fault_irq(irq));
    drv_model dev_u (.clk(clk), .cmd(cmd), .high_line(hi_line),
        .low_line(lo_line), .uv1(uv1), .low_flt(low_flt),
        .high_pull_n(hi_pull_n), .low_pull_n(lo_pull_n),
        .high_gate(hi_gate), .low_gate(lo_gate));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic end_sim;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // two-cycle high request, then straight to low side
    task automatic t_leg;
        req.high_side_command = 3'h7;
        cyc(2);
        chk({5'h0, hi_gate}, 8'h07);
        req = 6'h07;
        for (n = 1; cmd.high_side_command === 3'h7 && n < 900; n++) cyc(1);
        chk({7'h0, n >= 100}, 8'h01);
        for (n = 0; cmd.low_side_command !== 3'h7 && n < 900; n++) cyc(1);
        chk({7'h0, n >= 300}, 8'h01);
        chk({5'h0, lo_gate}, 8'h07);
        req = 6'h00;
        cyc(400);
    endtask
    // our own pull: long enough, locks commands, not a fault
    task automatic t_shdn;
        req.high_side_command = 3'h7;
        cyc(110);
        sd_hi = 1'h1;
        cyc(1);
        sd_hi = 1'h0;
        cyc(1);
        for (n = 0; !hi_line && n < 2000; n++) cyc(1);
        chk({7'h0, n >= 1200}, 8'h01);
        chk({1'h0, hi_seen, cmd}, 8'h00);
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        for (n = 0; cmd.high_side_command !== 3'h7 && n < 900; n++) cyc(1);
        cyc(1);
        chk({5'h0, hi_gate}, 8'h07);
    endtask
    // device faults on both lines, then a low-side pull
    task automatic t_fault;
        low_flt = 1'h1;
        cyc(6);
        chk({lo_seen, irq, cmd}, 8'hc0);
        req = 6'h00;
        low_flt = 1'h0;
        uv1 = 1'h1;
        cyc(6);
        chk({7'h0, hi_seen}, 8'h01);
        uv1 = 1'h0;
        cyc(4);
        clr = 1'h1;
        cyc(1);
        clr = 1'h0;
        cyc(2);
        chk({5'h0, hi_seen, lo_seen, irq}, 8'h00);
        sd_lo = 1'h1;
        cyc(1);
        sd_lo = 1'h0;
        cyc(1);
        for (n = 0; !lo_line && n < 2000; n++) cyc(1);
        chk({6'h0, n >= 1200, lo_seen}, 8'h02);
    endtask
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'h1;
        cyc(2);
        t_leg();
        t_shdn();
        t_fault();
        end_sim();
    end
endmodule
`default_nettype wire

// ### core/gate_ctrl.sv
`include "gate_ctrl_cfg.svh"
`default_nettype none
module gate_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    // user's requested commands per phase
    input wire gate_ctrl_pkg::cmd_s req,
    // user asks for a shutdown pulse on either line (pulse)
    input wire logic shutdown_high_req,
    input wire logic shutdown_low_req,
    // user acknowledges a fault and re-enables commands (pulse)
    input wire logic fault_clear,
    // fault line levels as seen on the pins
    input wire logic high_side_fault_shutdown_i,
    input wire logic low_side_fault_shutdown_i,
    // commands to the driver
    output gate_ctrl_pkg::cmd_s cmd,
    // open-drain drive of the fault lines
    output gate_ctrl_pkg::fault_pins_s fault_pins,
    // sticky fault status and interrupt-style level
    output logic high_fault_seen,
    output logic low_fault_seen,
    output logic fault_irq
);
    import gate_ctrl_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [1:0] hi_sync; // two-stage synchroniser, high line
        logic [1:0] lo_sync; // two-stage synchroniser, low line
        logic hi_seen;
        logic lo_seen;
        logic irq;
        logic [2:0] lockout; // commands held off until fault_clear
        sd_e sd_st;
        logic sd_side;       // 1 = high line, 0 = low line
        logic [`CNT_W-1:0] sd_cnt;
        fault_pins_s pins;
    } top_state_s;
    top_state_s s_r;
    top_state_s s_nxt;

    localparam logic [`CNT_W-1:0] SHDN = `CNT_W'(`SHDN_PULSE_CYC);

    logic hi_low;   // synchronised high line is low
    logic lo_low;   // synchronised low line is low
    logic force_off;
    logic [2:0] leg_hi;
    logic [2:0] leg_lo;

    // second stage only is read; first stage feeds nothing else
    assign hi_low = !s_r.hi_sync[1];
    assign lo_low = !s_r.lo_sync[1];
    // any fault, our own shutdown, or unacknowledged fault stops legs
    assign force_off = (s_r.lockout != '0) || hi_low || lo_low;

    // -------------------------------------------------------------
    // phase legs
    // -------------------------------------------------------------
    // each leg keeps dead time, and widths except under force_off, so the driver need not
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_leg
            phase_leg u_leg (
                .clk(clk),
                .arst_n(arst_n),
                .req_high(req.high_side_command[g]),
                .req_low(req.low_side_command[g]),
                .force_off(force_off),
                .high_cmd(leg_hi[g]),
                .low_cmd(leg_lo[g])
            );
        end
    endgenerate

    // -------------------------------------------------------------
    // fault watch and shutdown pulse
    // -------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.hi_sync = {s_r.hi_sync[0], high_side_fault_shutdown_i};
        s_nxt.lo_sync = {s_r.lo_sync[0], low_side_fault_shutdown_i};
        // a line pulled low by the driver (or the limit flag wired on)
        // is a fault; our own pulse is excluded
        // sticky bits: set wins over clear
        if (fault_clear) begin
            s_nxt.hi_seen = 1'b0;
            s_nxt.lo_seen = 1'b0;
            s_nxt.irq = 1'b0;
            s_nxt.lockout = '0;
        end
        if (hi_low && !(s_r.sd_st != SD_IDLE && s_r.sd_side)) begin
            s_nxt.hi_seen = 1'b1;
            s_nxt.lockout[0] = 1'b1;
        end
        // low line is the interrupt; all commands go low at once
        if (lo_low && !(s_r.sd_st != SD_IDLE && !s_r.sd_side)) begin
            s_nxt.lo_seen = 1'b1;
            s_nxt.irq = 1'b1;
            s_nxt.lockout[1] = 1'b1;
        end
        case (s_r.sd_st)
            SD_IDLE: begin
                if (shutdown_high_req || shutdown_low_req) begin
                    s_nxt.sd_st = SD_PULL;
                    s_nxt.sd_side = shutdown_high_req;
                    s_nxt.sd_cnt = SHDN;
                    s_nxt.lockout[2] = 1'b1;
                    // enable low = drive the open-drain line low
                    if (shutdown_high_req) begin
                        s_nxt.pins.high_side_fault_shutdown_oe_n = 1'b0;
                    end else begin
                        s_nxt.pins.low_side_fault_shutdown_oe_n = 1'b0;
                    end
                end
            end
            SD_PULL: begin
                // hold low a full 6 us so the 3.3 us filter passes it
                if (s_r.sd_cnt == '0) begin
                    s_nxt.sd_st = SD_WAIT;
                    s_nxt.pins.high_side_fault_shutdown_oe_n = 1'b1;
                    s_nxt.pins.low_side_fault_shutdown_oe_n = 1'b1;
                    s_nxt.sd_cnt = `CNT_W'(3);
                end else begin
                    s_nxt.sd_cnt = s_r.sd_cnt - `CNT_W'(1);
                end
            end
            SD_WAIT: begin
                // let the pulled-up line recover through the synchroniser
                if (s_r.sd_cnt == '0) begin
                    s_nxt.sd_st = SD_IDLE;
                end else begin
                    s_nxt.sd_cnt = s_r.sd_cnt - `CNT_W'(1);
                end
            end
            default: begin
                s_nxt.sd_st = SD_IDLE;
            end
        endcase
    end

    // state register; pins start released
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '{hi_sync: 2'b11, lo_sync: 2'b11, hi_seen: 1'b0,
                     lo_seen: 1'b0, irq: 1'b0, lockout: 3'b000,
                     sd_st: SD_IDLE, sd_side: 1'b0, sd_cnt: '0,
                     pins: '{1'b0, 1'b1, 1'b0, 1'b1}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // leg outputs are already registered; commands never tri-state
    assign cmd.high_side_command = leg_hi;
    assign cmd.low_side_command = leg_lo;
    assign fault_pins = s_r.pins;
    assign high_fault_seen = s_r.hi_seen;
    assign low_fault_seen = s_r.lo_seen;
    assign fault_irq = s_r.irq;
endmodule
`default_nettype wire

// ### core/gate_ctrl_cfg.svh
`ifndef GATE_CTRL_CFG_SVH
`define GATE_CTRL_CFG_SVH
// clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS 5000
// least command pulse width, ns
`define MIN_PULSE_NS 500
`define MIN_PULSE_CYC ((`MIN_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// least dead time between complementary commands, ns
`define DEAD_TIME_NS 1500
`define DEAD_TIME_CYC ((`DEAD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// least shutdown pulse width on a fault line, ns
`define SHDN_PULSE_NS 6000
`define SHDN_PULSE_CYC ((`SHDN_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// least carrier period for 20 kHz, ns
`define CARRIER_PERIOD_NS 50000
`define CARRIER_PERIOD_CYC ((`CARRIER_PERIOD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// counter width covering every count above
`define CNT_W 14
`endif

// ### core/gate_ctrl_pkg.sv
`default_nettype none
package gate_ctrl_pkg;
    // one command pair per phase
    typedef struct packed {
        logic [2:0] high_side_command;
        logic [2:0] low_side_command;
    } cmd_s;
    // open-drain view of both fault/shutdown lines
    typedef struct packed {
        logic high_side_fault_shutdown_o;
        logic high_side_fault_shutdown_oe_n;
        logic low_side_fault_shutdown_o;
        logic low_side_fault_shutdown_oe_n;
    } fault_pins_s;
    // per-phase leg states
    typedef enum logic [3:0] {
        LEG_OFF  = 4'b0001,
        LEG_HIGH = 4'b0010,
        LEG_LOW  = 4'b0100,
        LEG_DEAD = 4'b1000
    } leg_e;
    // shutdown pulse states
    typedef enum logic [2:0] {
        SD_IDLE  = 3'b001,
        SD_PULL  = 3'b010,
        SD_WAIT  = 3'b100
    } sd_e;
endpackage
`default_nettype wire

// ### core/phase_leg.sv
`include "gate_ctrl_cfg.svh"
`default_nettype none
// one inverter leg: enforces pulse width (not under force_off) and dead time on its command pair
module phase_leg (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_high,
    input wire logic req_low,
    input wire logic force_off,
    output logic high_cmd,
    output logic low_cmd
);
    import gate_ctrl_pkg::*;
    typedef struct packed {
        leg_e st;
        logic [`CNT_W-1:0] cnt;
        logic hi;
        logic lo;
    } leg_state_s;
    leg_state_s s_r;
    leg_state_s s_nxt;

    localparam logic [`CNT_W-1:0] PULSE = `CNT_W'(`MIN_PULSE_CYC);
    localparam logic [`CNT_W-1:0] DEAD = `CNT_W'(`DEAD_TIME_CYC);

    // -------------------------------------------------------------
    // leg sequencing
    // -------------------------------------------------------------
    // HIGH and LOW last at least PULSE unless force_off, DEAD at least as long, so every level is wide enough
    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - `CNT_W'(1);
        end
        case (s_r.st)
            LEG_OFF: begin
                // both low; may enter either side once settled
                if (s_r.cnt == '0 && !force_off) begin
                    if (req_high) begin
                        s_nxt.st = LEG_HIGH;
                        s_nxt.hi = 1'b1;
                        s_nxt.cnt = PULSE;
                    end else if (req_low) begin
                        s_nxt.st = LEG_LOW;
                        s_nxt.lo = 1'b1;
                        s_nxt.cnt = PULSE;
                    end
                end
            end
            LEG_HIGH, LEG_LOW: begin
                // force_off skips the width wait: safety over shape
                if (force_off || (s_r.cnt == '0 &&
                    ((s_r.st == LEG_HIGH) ? !req_high : !req_low))) begin
                    s_nxt.st = LEG_DEAD;
                    s_nxt.hi = 1'b0;
                    s_nxt.lo = 1'b0;
                    s_nxt.cnt = (DEAD > PULSE) ? DEAD : PULSE;
                end
            end
            LEG_DEAD: begin
                // device adds no dead time, so we hold both low here
                if (s_r.cnt == '0) begin
                    s_nxt.st = LEG_OFF;
                end
            end
            default: begin
                s_nxt.st = LEG_OFF;
                s_nxt.hi = 1'b0;
                s_nxt.lo = 1'b0;
                s_nxt.cnt = '0;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '{st: LEG_OFF, cnt: '0, hi: 1'b0, lo: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flip-flops, always driven
    assign high_cmd = s_r.hi;
    assign low_cmd = s_r.lo;
endmodule
`default_nettype wire
